// [bench/flash_self_program_latch_unit_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fsplu_defs.svh"
module flash_self_program_latch_unit_tb;
    logic        REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
    logic        FL_PROG, FL_ERASE, FL_RD, CPU_STALL;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, r;
    logic [23:0] FL_ADDR, FL_WDATA, FL_RDATA, rd_addr, d;
    logic [23:0] row_d [64];
    logic [15:0] ea;
    logic [7:0]  pg;
    int          mismatches, num_checks, seed, n_prog, n_erase;
    always #25 REF_CLK = ~REF_CLK;
    fsplu_top #(.OP_CYCLES(80)) u_dut (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR),
        .FL_WDATA(FL_WDATA), .FL_PROG(FL_PROG), .FL_ERASE(FL_ERASE),
        .FL_RD(FL_RD), .FL_RDATA(FL_RDATA), .CPU_STALL(CPU_STALL)
    );
    fsplu_flash_model u_flash (
        .clk(REF_CLK), .addr(FL_ADDR), .wdata(FL_WDATA), .prog(FL_PROG),
        .erase(FL_ERASE), .rd(FL_RD), .rdata(FL_RDATA)
    );
    // Array activity as seen at the pins
    always @(posedge REF_CLK) begin
        n_prog <= n_prog + int'(FL_PROG === 1'b1);
        n_erase <= n_erase + int'(FL_ERASE === 1'b1);
        if (FL_RD === 1'b1)
            rd_addr <= FL_ADDR;
    end
    ////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer, then one idle edge so strobes never double up
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            give_verdict();
        end
        @(posedge REF_CLK);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // Table access; two edges for the latch cycle
    task automatic tbl(input logic [15:0] a, input logic [23:0] wd, input logic [2:0] acc);
        wr(`FSPLU_OFF_ADDR, {16'h0, a});
        wr(`FSPLU_OFF_WDATA, {8'h0, wd});
        wr(`FSPLU_OFF_ACC, {29'h0, acc});
        repeat (2) @(posedge REF_CLK);
    endtask
    // Flash read through the data register; control bit 2 picks the window
    task automatic rdf(input logic [31:0] ctl, input logic [15:0] a);
        wr(`FSPLU_OFF_ADDR, {16'h0, a});
        wr(`FSPLU_OFF_NVCTL, ctl);
        apb(1'b0, `FSPLU_OFF_RDATA, 32'h0);
        repeat (2) @(posedge REF_CLK);
    endtask
    // Unlock, launch, wait out the stall under a bound
    task automatic run_op(input logic [31:0] ctl);
        int n;
        n = 0;
        wr(`FSPLU_OFF_KEY, 32'h55);
        wr(`FSPLU_OFF_KEY, 32'haa);
        wr(`FSPLU_OFF_NVCTL, ctl);
        repeat (10) if (CPU_STALL !== 1'b1) @(posedge REF_CLK);
        chk({31'h0, CPU_STALL}, 32'h1);
        while (CPU_STALL !== 1'b0 && n < 300) begin
            @(posedge REF_CLK);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            give_verdict();
        end
        apb(1'b0, `FSPLU_OFF_NVCTL, 32'h0);
        chk({31'h0, r[15]}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {REF_CLK, RST_N, PSEL, PENABLE, PWRITE} = 5'h00;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        {mismatches, num_checks, n_prog, n_erase} = 128'h0;
        seed = 12;
        repeat (6) @(posedge REF_CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        rdc(`FSPLU_OFF_NVCTL, 32'h0);
        rdc(`FSPLU_OFF_KEY, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Broken unlock: none, interrupted pair, reversed pair
        for (int i = 0; i < 3; i++) begin
            if (i == 1) begin
                wr(`FSPLU_OFF_KEY, 32'h55);
                wr(`FSPLU_OFF_TBLPG, 32'h0);
            end
            if (i > 0)
                wr(`FSPLU_OFF_KEY, 32'haa);
            if (i == 2)
                wr(`FSPLU_OFF_KEY, 32'h55);
            wr(`FSPLU_OFF_NVCTL, 32'h8001);
            apb(1'b0, `FSPLU_OFF_STAT, 32'h0);
            chk({31'h0, CPU_STALL}, 32'h0);
            chk({29'h0, r[2:0]}, 32'h4);
        end
        // Address forming, odd passes set page bit 7 to reach configuration space
        for (int i = 0; i < 4; i++) begin
            pg = {i[0], 7'($random(seed))};
            ea = 16'($random(seed));
            wr(`FSPLU_OFF_TBLPG, {24'h0, pg});
            wr(`FSPLU_OFF_WINPG, {24'h0, ~pg});
            rdf(32'h0, ea);
            chk({8'h0, rd_addr}, {8'h0, pg, ea});
            rdc(`FSPLU_OFF_RDATA, 32'h00ffffff);
            rdf(32'h4, ea | 16'h8000);
            chk({8'h0, rd_addr}, {9'h0, ~pg, ea[14:0]});
        end
        // Full row loaded in reverse, one latch rewritten
        pg = 8'h02;
        ea = {1'b0, 5'($random(seed)), 10'h100};
        wr(`FSPLU_OFF_TBLPG, {24'h0, pg});
        for (int i = 63; i >= 0; i--) begin
            row_d[i] = 24'($random(seed));
            tbl(ea + 16'(2 * i), row_d[i], 3'h3);
        end
        row_d[5] = ~row_d[5];
        tbl(ea + 16'h000a, row_d[5], 3'h3);
        chk(32'(n_prog), 32'h0);
        run_op(32'h8001);
        chk(32'(n_prog), 32'h40);
        for (int i = 0; i < 64; i++)
            chk({8'h0, u_flash.peek({pg, ea + 16'(2 * i)})}, {8'h0, row_d[i]});
        // Single word into the next row
        // fresh location only
        d = 24'($random(seed));
        tbl(ea + 16'h0080, d, 3'h3);
        run_op(32'h8000);
        chk(32'(n_prog), 32'h41);
        chk({8'h0, u_flash.peek({pg, ea + 16'h0080})}, {8'h0, d});
        // Block erase clears both rows
        run_op(32'h8040);
        chk(32'(n_erase), 32'h1);
        chk({8'h0, u_flash.peek({pg, ea})}, 32'h00ffffff);
        chk({8'h0, u_flash.peek({pg, ea + 16'h0080})}, 32'h00ffffff);
        give_verdict();
    end
endmodule // flash_self_program_latch_unit_tb
`default_nettype wire

// [bench/fsplu_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fsplu_flash_model (
    input wire logic        clk,
    input wire logic [23:0] addr,
    input wire logic [23:0] wdata,
    input wire logic        prog,
    input wire logic        erase,
    input wire logic        rd,
    output logic [23:0]     rdata
);
    logic [23:0] mem [int];
    initial rdata = 24'h5a5a5a;
    // Cells never written read as erased
    function automatic logic [23:0] peek(input logic [23:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 24'hffffff;
    endfunction
    // Data stands one edge only, then scrambles
    always @(posedge clk) begin
        if (erase)
            for (int i = 0; i < 1024; i++)
                if (mem.exists(int'({addr[23:10], 10'h000}) + i))
                    mem.delete(int'({addr[23:10], 10'h000}) + i);
        if (prog)
            mem[int'(addr)] = wdata;
        rdata <= rd ? peek(addr) : ~rdata;
    end
endmodule // fsplu_flash_model
`default_nettype wire

// [bench/fsplu_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fsplu_defs.svh"
module fsplu_top_sva #(
    parameter int OP_CYCLES = `FSPLU_OP_CYCLES
) (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic [23:0] FL_ADDR,
    input wire logic        FL_PROG,
    input wire logic        FL_ERASE,
    input wire logic        CPU_STALL
);
    logic        wr_ok, start_wr, tbl_go, rd_key, len_ok;
    logic [1:0]  key_ff, nxt_key;
    logic [9:0]  stall_ff;
    logic [7:0]  prog_ff;
    logic [16:0] row_ff;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////
    // Accepted writes; writes during a stall are dropped
    assign wr_ok    = PSEL && PENABLE && PWRITE && PREADY && !CPU_STALL;
    assign start_wr = wr_ok && PADDR == `FSPLU_OFF_NVCTL && PWDATA[15];
    assign tbl_go   = wr_ok && PADDR == `FSPLU_OFF_ACC && PWDATA[0];
    assign rd_key   = PSEL && PENABLE && PREADY && !PWRITE && PADDR == `FSPLU_OFF_KEY;
    assign len_ok   = int'(stall_ff) >= OP_CYCLES - 4 && int'(stall_ff) <= OP_CYCLES + 4;
    assign nxt_key  = PADDR != `FSPLU_OFF_KEY ? 2'h0 :
                      PWDATA[7:0] == 8'h55 ? 2'h1 :
                      PWDATA[7:0] == 8'haa && key_ff == 2'h1 ? 2'h2 : 2'h0;
    // Unlock progress: 1 after first key, 2 when armed
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N)
            key_ff <= 2'h0;
        else if (wr_ok)
            key_ff <= nxt_key;
    end
    // Per-operation counters, cleared once the core runs again
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stall_ff <= 10'h000;
            prog_ff  <= 8'h00;
            row_ff   <= 17'h00000;
        end else begin
            stall_ff <= CPU_STALL ? stall_ff + 10'h001 : 10'h000;
            prog_ff  <= CPU_STALL || FL_PROG ? prog_ff + {7'h00, FL_PROG} : 8'h00;
            if (FL_PROG && prog_ff == 8'h00)
                row_ff <= FL_ADDR[23:7];
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_quiet;
        !CPU_STALL [*3];
    endsequence
    sequence s_run;
        CPU_STALL [*8];
    endsequence
    // Launch gated by the full unlock pair
    refuse_start_a: assert property (start_wr && key_ff != 2'h2 |=> s_quiet)
        else $error("start launched without unlock");
    armed_start_a: assert property (start_wr && key_ff == 2'h2 |-> ##[1:3] s_run)
        else $error("armed start did not stall the core");
    // Array cycles only inside an operation, one row at most
    prog_stalled_a: assert property (FL_PROG || FL_ERASE |-> ##[0:1] CPU_STALL)
        else $error("flash cycle outside an operation");
    row_words_a: assert property (prog_ff <= 8'h40)
        else $error("more than one row programmed");
    one_row_a: assert property (FL_PROG && prog_ff != 8'h00 |-> FL_ADDR[23:7] == row_ff)
        else $error("programming crossed a row boundary");
    op_words_a: assert property ($fell(CPU_STALL) |-> prog_ff inside {8'h00, 8'h01, 8'h40})
        else $error("odd word count in one operation");
    erase_once_a: assert property (FL_ERASE |=> !FL_ERASE until !CPU_STALL)
        else $error("block erase pulsed twice");
    stall_len_a: assert property ($fell(CPU_STALL) |-> len_ok)
        else $error("operation length off");
    key_read_a: assert property (rd_key |-> PRDATA == 32'h0)
        else $error("key register readable");
    tbl_quick_a: assert property (tbl_go |=> !CPU_STALL [*2])
        else $error("table access stalled the core");
endmodule // fsplu_top_sva
bind fsplu_top fsplu_top_sva #(.OP_CYCLES(OP_CYCLES)) u_sva (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .FL_ADDR(FL_ADDR), .FL_PROG(FL_PROG),
    .FL_ERASE(FL_ERASE), .CPU_STALL(CPU_STALL)
);
`default_nettype wire

// [shared/fsplu_defs.svh]
`ifndef FSPLU_DEFS_SVH
`define FSPLU_DEFS_SVH

// APB register byte offsets
`define FSPLU_OFF_TBLPG      12'h000
`define FSPLU_OFF_WINPG      12'h004
`define FSPLU_OFF_NVCTL      12'h008
`define FSPLU_OFF_KEY        12'h00c
`define FSPLU_OFF_ADDR       12'h010
`define FSPLU_OFF_WDATA      12'h014
`define FSPLU_OFF_ACC        12'h018
`define FSPLU_OFF_RDATA      12'h01c
`define FSPLU_OFF_STAT       12'h020
`define FSPLU_OFF_OPCNT      12'h024

// Control register fields
`define FSPLU_CTL_START_BIT  15
`define FSPLU_CTL_ERASE_BIT  6
`define FSPLU_CTL_OP_LSB     0
`define FSPLU_CTL_RESET      16'h0000

// Access register fields
`define FSPLU_ACC_GO_BIT     0
`define FSPLU_ACC_WR_BIT     1
`define FSPLU_ACC_WIN_BIT    2

// Unlock key values
`define FSPLU_KEY_FIRST      8'h55
`define FSPLU_KEY_SECOND     8'haa

// Geometry
`define FSPLU_ROW_WORDS      64
`define FSPLU_ROW_BYTES      192
`define FSPLU_BLK_ROWS       8
`define FSPLU_BLK_WORDS      512
`define FSPLU_BLK_BYTES      1536
`define FSPLU_ERASED_WORD    24'hffffff

// Table write occupies two instruction cycles
`define FSPLU_TBLWR_CYCLES   2
// Default flash operation duration in clock cycles
`define FSPLU_OP_CYCLES      64

`endif

// [shared/fsplu_latch_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Latch array port between sequencer and holding latches
interface fsplu_latch_if;
    logic        wr;
    logic [5:0]  idx;
    logic [23:0] wdata;
    logic [5:0]  ridx;
    logic [23:0] rdata;
    modport master (output wr, output idx, output wdata, output ridx, input rdata);
    modport slave  (input wr, input idx, input wdata, input ridx, output rdata);
endinterface
`default_nettype wire

// [shared/fsplu_pkg.sv]
`default_nettype none
package fsplu_pkg;
    typedef enum logic [1:0] {
        FSPLU_ST_IDLE  = 2'b00,
        FSPLU_ST_TBL   = 2'b01,
        FSPLU_ST_BUSY  = 2'b10
    } fsplu_state_t;

    typedef enum logic [1:0] {
        FSPLU_OP_WORD  = 2'b00,
        FSPLU_OP_ROW   = 2'b01,
        FSPLU_OP_BLOCK = 2'b10,
        FSPLU_OP_NONE  = 2'b11
    } fsplu_op_t;
endpackage
`default_nettype wire

// [src/fsplu_key.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fsplu_defs.svh"
module fsplu_key (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       key_wr,
    input  wire logic       other_wr,
    input  wire logic [7:0] key_data,
    input  wire logic       consume,
    output logic            armed
);
    logic first_ff;
    logic armed_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if (consume) begin
            first_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if (key_wr) begin
            first_ff <= (key_data == `FSPLU_KEY_FIRST);
            armed_ff <= first_ff && (key_data == `FSPLU_KEY_SECOND);
        end else if (other_wr) begin
            first_ff <= 1'b0;
            armed_ff <= armed_ff;
        end
    end

    assign armed = armed_ff;
endmodule // fsplu_key
`default_nettype wire

// [src/fsplu_latches.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fsplu_defs.svh"
module fsplu_latches #(
    parameter int ROW_WORDS = `FSPLU_ROW_WORDS
) (
    input  wire logic          clk,
    fsplu_latch_if.slave       lat
);
    // No reset: latches power up unknown, software fills unused ones
    logic [23:0] mem_ff [ROW_WORDS];

    // Last write to a latch wins, any order
    always_ff @(posedge clk) begin
        if (lat.wr) begin
            mem_ff[lat.idx] <= lat.wdata;
        end
    end

    assign lat.rdata = mem_ff[lat.ridx];
endmodule // fsplu_latches
`default_nettype wire

// [src/fsplu_top.sv]
// Notes on behaviour
// - Window reads take address bit 15 from window page bit 0
// - Table accesses need no alignment; configuration space reads allowed
// - Rows hold 64 instruction words, 192 program bytes
// - Operations: erase eight-row block, program row, program a row's first word from latch 0
// - Blocks align to 1536 bytes, rows to 192 bytes
// - Table writes fill latches only until programming runs
// - Row write succeeds with any number of loaded latches
// - Latches take any order; latest write replaces earlier
// - Table write completes as latch write in two cycles
// - Each programming cycle commits at most one row
// - Control register selects erase/program kind, holds start bit
// - Unlock key register is write-only protection
// - Start requires consecutive key writes 55h then AAh
// - Start bit 15 launches, clears itself when done
// - Processor stalls while erase or program runs
`timescale 1ns/100ps
`default_nettype none
`include "fsplu_defs.svh"
module fsplu_top #(
    parameter int OP_CYCLES = `FSPLU_OP_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic [23:0]      FL_ADDR,
    output logic [23:0]      FL_WDATA,
    output logic             FL_PROG,
    output logic             FL_ERASE,
    output logic             FL_RD,
    input  wire logic [23:0] FL_RDATA,
    output logic             CPU_STALL
);
    ////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end
    logic rst_n;
    assign rst_n = rst_n_ff;

    ////////////////////////////////////////////////////////////////////
    // APB decode
    logic wr_en;
    logic rd_en;
    logic mapped;
    fsplu_pkg::fsplu_state_t state_ff;
    logic busy;
    assign busy  = (state_ff != fsplu_pkg::FSPLU_ST_IDLE);
    // Writes and flash read strobes are dropped while busy; the access phase does not wait
    assign wr_en = PSEL && PENABLE && PWRITE && !busy;
    assign rd_en = PSEL && PENABLE && !PWRITE && !busy;
    always_comb begin
        unique case (PADDR)
            `FSPLU_OFF_TBLPG, `FSPLU_OFF_WINPG, `FSPLU_OFF_NVCTL, `FSPLU_OFF_KEY,
            `FSPLU_OFF_ADDR, `FSPLU_OFF_WDATA, `FSPLU_OFF_ACC, `FSPLU_OFF_RDATA,
            `FSPLU_OFF_STAT, `FSPLU_OFF_OPCNT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Software-visible registers
    logic [7:0]  tblpg_ff;
    logic [7:0]  winpg_ff;
    logic [15:0] ctl_ff;
    logic [15:0] ea_ff;
    logic [23:0] wdata_ff;
    logic [23:0] rdata_ff;
    logic [15:0] opcnt_ff;
    logic        refused_ff;
    logic        done;
    logic        armed;
    logic        start_req;
    logic        key_wr;

    assign key_wr    = wr_en && (PADDR == `FSPLU_OFF_KEY);
    assign start_req = wr_en && (PADDR == `FSPLU_OFF_NVCTL) && PWDATA[`FSPLU_CTL_START_BIT];

    // Page and address registers
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tblpg_ff <= 8'h00;
            winpg_ff <= 8'h00;
            ea_ff    <= 16'h0000;
            wdata_ff <= 24'h000000;
        end else if (wr_en) begin
            if (PADDR == `FSPLU_OFF_TBLPG) tblpg_ff <= PWDATA[7:0];
            if (PADDR == `FSPLU_OFF_WINPG) winpg_ff <= PWDATA[7:0];
            if (PADDR == `FSPLU_OFF_ADDR)  ea_ff    <= PWDATA[15:0];
            if (PADDR == `FSPLU_OFF_WDATA) wdata_ff <= PWDATA[23:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff     <= `FSPLU_CTL_RESET;
            refused_ff <= 1'b0;
        end else if (done) begin
            ctl_ff[`FSPLU_CTL_START_BIT] <= 1'b0;
        end else if (wr_en && PADDR == `FSPLU_OFF_NVCTL) begin
            ctl_ff     <= {PWDATA[15] && armed, PWDATA[14:0]};
            refused_ff <= start_req && !armed;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Unlock key, write-only
    // key only gates start
    fsplu_key u_key (
        .clk      (REF_CLK),
        .rst_n    (rst_n),
        .key_wr   (key_wr),
        .other_wr (wr_en && !key_wr),
        .key_data (PWDATA[7:0]),
        .consume  (start_req),
        .armed    (armed)
    );

    ////////////////////////////////////////////////////////////////////
    // Holding latches
    fsplu_latch_if lat ();
    fsplu_latches #(.ROW_WORDS(`FSPLU_ROW_WORDS)) u_lat (
        .clk (REF_CLK),
        .lat (lat)
    );

    logic [23:0] tbl_addr;
    logic [23:0] win_addr;
    assign tbl_addr = {tblpg_ff, ea_ff};
    assign win_addr = {1'b0, winpg_ff, ea_ff[14:0]};

    // Address offset within the 192-byte row (2 address units per word)
    logic [23:0] row_off;
    assign row_off = tbl_addr % 24'(`FSPLU_ROW_WORDS * 2);

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    logic        acc_go;
    logic        acc_wr;
    logic        acc_win;
    logic [1:0]  tcnt_ff;
    logic [15:0] ocnt_ff;
    logic [6:0]  rcnt_ff;
    logic [23:0] base_ff;
    fsplu_pkg::fsplu_op_t op_ff;
    assign acc_go  = wr_en && (PADDR == `FSPLU_OFF_ACC) && PWDATA[`FSPLU_ACC_GO_BIT];
    assign acc_wr  = PWDATA[`FSPLU_ACC_WR_BIT];
    assign acc_win = PWDATA[`FSPLU_ACC_WIN_BIT];
    assign done    = (state_ff == fsplu_pkg::FSPLU_ST_BUSY) && (ocnt_ff == 16'h0000);

    // no alignment check on table access
    assign lat.wr    = acc_go && acc_wr && !acc_win;
    assign lat.idx   = row_off[6:1];
    assign lat.wdata = wdata_ff;
    assign lat.ridx  = rcnt_ff[5:0];

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= fsplu_pkg::FSPLU_ST_IDLE;
            tcnt_ff  <= 2'd0;
            ocnt_ff  <= 16'h0000;
            op_ff    <= fsplu_pkg::FSPLU_OP_NONE;
            base_ff  <= 24'h000000;
            rcnt_ff  <= 7'd0;
            opcnt_ff <= 16'h0000;
        end else begin
            unique case (state_ff)
                fsplu_pkg::FSPLU_ST_IDLE: begin
                    if (lat.wr) begin
                        state_ff <= fsplu_pkg::FSPLU_ST_TBL;
                        tcnt_ff  <= 2'(`FSPLU_TBLWR_CYCLES - 1);
                    end else if (start_req && armed) begin
                        state_ff <= fsplu_pkg::FSPLU_ST_BUSY;
                        ocnt_ff  <= 16'(OP_CYCLES - 1);
                        rcnt_ff  <= 7'd0;
                        op_ff    <= PWDATA[`FSPLU_CTL_ERASE_BIT]
                                    ? fsplu_pkg::FSPLU_OP_BLOCK
                                    : fsplu_pkg::fsplu_op_t'(PWDATA[1:0]);
                        base_ff  <= PWDATA[`FSPLU_CTL_ERASE_BIT]
                                    ? tbl_addr - tbl_addr % 24'(`FSPLU_BLK_WORDS * 2)
                                    : tbl_addr - row_off;
                    end
                end
                fsplu_pkg::FSPLU_ST_TBL: begin
                    tcnt_ff <= tcnt_ff - 2'd1;
                    if (tcnt_ff == 2'd1) state_ff <= fsplu_pkg::FSPLU_ST_IDLE;
                end
                fsplu_pkg::FSPLU_ST_BUSY: begin
                    ocnt_ff <= ocnt_ff - 16'h0001;
                    if (rcnt_ff != 7'(`FSPLU_ROW_WORDS)) rcnt_ff <= rcnt_ff + 7'd1;
                    if (done) begin
                        state_ff <= fsplu_pkg::FSPLU_ST_IDLE;
                        opcnt_ff <= opcnt_ff + 16'h0001;
                    end
                end
                default: state_ff <= fsplu_pkg::FSPLU_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flash array strobes, all registered
    // row of 64 words
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            FL_ADDR  <= 24'h000000;
            FL_WDATA <= 24'h000000;
            FL_PROG  <= 1'b0;
            FL_ERASE <= 1'b0;
            FL_RD    <= 1'b0;
        end else begin
            FL_PROG  <= 1'b0;
            FL_ERASE <= 1'b0;
            FL_RD    <= 1'b0;
            if (state_ff == fsplu_pkg::FSPLU_ST_BUSY && rcnt_ff < 7'(`FSPLU_ROW_WORDS)) begin
                FL_ADDR  <= base_ff + {16'h0000, rcnt_ff, 1'b0};
                FL_WDATA <= lat.rdata;
                unique case (op_ff)
                    fsplu_pkg::FSPLU_OP_WORD:  FL_PROG  <= (rcnt_ff == 7'd0);
                    fsplu_pkg::FSPLU_OP_ROW:   FL_PROG  <= 1'b1;
                    fsplu_pkg::FSPLU_OP_BLOCK: FL_ERASE <= (rcnt_ff == 7'd0);
                    fsplu_pkg::FSPLU_OP_NONE:  FL_PROG  <= 1'b0;
                endcase
            end else if (rd_en && PADDR == `FSPLU_OFF_RDATA) begin
                FL_ADDR <= ctl_ff[`FSPLU_CTL_OP_LSB + 2] ? win_addr : tbl_addr;
                FL_RD   <= 1'b1;
            end
        end
    end

    // Latest flash read data; the array answers one edge after the strobe
    logic rd_pend_ff;
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_ff <= 1'b0;
            rdata_ff   <= 24'h000000;
        end else begin
            rd_pend_ff <= FL_RD;
            if (rd_pend_ff) rdata_ff <= FL_RDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB answer, registered from the setup phase, whether busy or idle
    // stall in the BUSY state only, not during table writes
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA    <= 32'h00000000;
            PREADY    <= 1'b0;
            PSLVERR   <= 1'b0;
            CPU_STALL <= 1'b0;
        end else begin
            CPU_STALL <= (state_ff == fsplu_pkg::FSPLU_ST_BUSY);
            PREADY    <= PSEL && !PENABLE;
            PSLVERR   <= PSEL && !PENABLE && !mapped;
            if (PSEL && !PENABLE && !PWRITE) begin
                unique case (PADDR)
                    `FSPLU_OFF_TBLPG: PRDATA <= {24'h000000, tblpg_ff};
                    `FSPLU_OFF_WINPG: PRDATA <= {24'h000000, winpg_ff};
                    `FSPLU_OFF_NVCTL: PRDATA <= {16'h0000, ctl_ff};
                    `FSPLU_OFF_ADDR:  PRDATA <= {16'h0000, ea_ff};
                    `FSPLU_OFF_WDATA: PRDATA <= {8'h00, wdata_ff};
                    `FSPLU_OFF_RDATA: PRDATA <= {8'h00, rdata_ff};
                    `FSPLU_OFF_STAT:  PRDATA <= {29'h0, refused_ff, armed, busy};
                    `FSPLU_OFF_OPCNT: PRDATA <= {16'h0000, opcnt_ff};
                    default:          PRDATA <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // fsplu_top
`default_nettype wire
